//--- inc/port_cfg_consts.vh
// constants for the port configuration and keypad wake block
`ifndef PORT_CFG_CONSTS_VH
`define PORT_CFG_CONSTS_VH
// register addresses
`define ADDR_KEYPAD_MASK    8'h86
`define ADDR_P2_AUX_MODE    8'ha4
`define ADDR_P0_MODE_A      8'h84
`define ADDR_P0_MODE_B      8'h85
`define ADDR_P1_MODE_A      8'h91
`define ADDR_P1_MODE_B      8'h92
`define ADDR_P2_SECOND_MODE 8'ha5
`define ADDR_PORT0_LATCH    8'h80
`define ADDR_PORT1_LATCH    8'h90
`define ADDR_PORT2_LATCH    8'ha0
`define ADDR_AUX_CONTROL    8'ha2
`define ADDR_P0_PINS        8'h81
`define ADDR_P1_PINS        8'h93
`define ADDR_P2_PINS        8'ha1
// reset values
`define RST_ZERO            8'h00
`define RST_ONES            8'hff
// aux mode fields
`define AUX_P2_SCHMITT      7
`define AUX_P1_SCHMITT      6
`define AUX_P0_SCHMITT      5
`define AUX_CLK_OUT_EN      4
`define AUX_T1_TOGGLE_EN    3
`define AUX_T0_TOGGLE_EN    2
// aux control field
`define AUXC_KEYPAD_FLAG    1
// mode encodings {bit_a, bit_b}
`define MODE_QUASI          2'h0
`define MODE_PUSH_PULL      2'h1
`define MODE_INPUT_ONLY     2'h2
`define MODE_OPEN_DRAIN     2'h3
// strong pull-up pulse length, cpu clocks
`define STRONG_PULSE_CLKS   2'h2
// clock out divider: one sixth of cpu clock
`define CLK_OUT_DIV         3'h6
`endif

//--- rtl/port_config_and_keypad_wake.v
// port configuration, pin drivers and keypad wake logic
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
`include "port_cfg_consts.vh"

module port_config_and_keypad_wake #(
   parameter NPIN = 8
) (
   // clock and reset
   input  wire             clk,
   input  wire             sys_rst,
   // register port
   input  wire [7:0]       reg_addr,
   input  wire [7:0]       reg_wdata,
   input  wire             reg_wr,
   input  wire             reg_rd,
   output reg  [7:0]       reg_rdata,
   // static configuration
   input  wire             reset_level_high,
   input  wire             internal_reset,
   input  wire             crystal_osc,
   input  wire             rc_or_ext_clk,
   input  wire             keypad_irq_enable,
   // timer overflow pulses
   input  wire             timer0_ovf,
   input  wire             timer1_ovf,
   // pins: input, pulldown, strong and weak pull-ups, schmitt select
   input  wire [NPIN-1:0]  p0_in,
   input  wire [NPIN-1:0]  p1_in,
   input  wire [NPIN-1:0]  p2_in,
   output reg  [NPIN-1:0]  p0_pull_down,
   output reg  [NPIN-1:0]  p1_pull_down,
   output reg  [NPIN-1:0]  p2_pull_down,
   output reg  [NPIN-1:0]  p0_strong_up,
   output reg  [NPIN-1:0]  p1_strong_up,
   output reg  [NPIN-1:0]  p2_strong_up,
   output reg  [NPIN-1:0]  p0_weak_up,
   output reg  [NPIN-1:0]  p1_weak_up,
   output reg  [NPIN-1:0]  p2_weak_up,
   output reg  [NPIN-1:0]  p0_schmitt,
   output reg  [NPIN-1:0]  p1_schmitt,
   output reg  [NPIN-1:0]  p2_schmitt,
   output reg  [NPIN-1:0]  p2_in_enable,
   // special outputs
   output reg              timer0_toggle,
   output reg              timer1_toggle,
   output reg              clock_out_pin,
   output reg              clock_out_active,
   // keypad interrupt and wake
   output wire             keypad_irq,
   output wire             keypad_wake
);

   // -------------------------------------------------------------------
   // registers
   // -------------------------------------------------------------------
   reg  [7:0] keypad_enable_mask_r;
   reg  [7:0] port2_aux_mode_r;
   reg  [7:0] port2_second_mode_r;
   reg  [7:0] p0_mode_a_r;
   reg  [7:0] p0_mode_b_r;
   reg  [7:0] p1_mode_a_r;
   reg  [7:0] p1_mode_b_r;
   reg  [7:0] p0_latch_r;
   reg  [7:0] p1_latch_r;
   reg  [7:0] p2_latch_r;
   reg  [7:0] p0_latch_d_r;
   reg  [7:0] p1_latch_d_r;
   reg  [7:0] p2_latch_d_r;
   reg  [7:0] p0_boost_r;
   reg  [7:0] p1_boost_r;
   reg  [7:0] p2_boost_r;
   reg        keypad_flag_r;
   reg  [2:0] clk_div_r;
   reg  [7:0] p0_s1_r;
   reg  [7:0] p0_s2_r;
   reg  [7:0] p0_s3_r;
   reg  [7:0] p0_sync_r;
   reg  [7:0] p1_s1_r;
   reg  [7:0] p1_s2_r;
   reg  [7:0] p2_s1_r;
   reg  [7:0] p2_s2_r;
   reg  [7:0] p1_s3_r, p1_sync_r;
   reg  [7:0] p2_s3_r, p2_sync_r;
   wire [7:0] rst_latch;
   wire [7:0] p2_mode_a;
   wire       kp_hit;
   wire       kp_flag_clr;

   // reset level of every latch follows the config bit
   assign rst_latch = reset_level_high ? `RST_ONES : `RST_ZERO;
   // aux bits 1,0 are bit_a of port 2 pins 1,0; others read as bit_a zero
   assign p2_mode_a = {6'h00, port2_aux_mode_r[1:0]};

   // -------------------------------------------------------------------
   // pin drive decode
   // -------------------------------------------------------------------
   // {pulldown, strong, weak} for one pin from mode, latch and boost
   function [2:0] drive;
      input [1:0] mode;
      input       latch;
      input       boost;
      begin
         case (mode)
            `MODE_QUASI:      drive = {~latch, boost & latch, latch};
            `MODE_PUSH_PULL:  drive = {~latch, latch, 1'b0};
            `MODE_INPUT_ONLY: drive = 3'h0;
            `MODE_OPEN_DRAIN: drive = {~latch, 2'h0};
            default:          drive = 3'h0;
         endcase
      end
   endfunction

   // per-pin decode; port 1 bits 2,3 forced open drain
   genvar g;
   generate
      for (g = 0; g < NPIN; g = g + 1) begin : pin_g
         wire [1:0] m1;
         wire [2:0] d0;
         wire [2:0] d1;
         wire [2:0] d2;
         wire       xtal_pin;
         assign m1 = (g == 2 || g == 3) ? `MODE_OPEN_DRAIN
                   : {p1_mode_a_r[g], p1_mode_b_r[g]};
         assign xtal_pin = (g < 2) && crystal_osc;
         assign d0 = drive({p0_mode_a_r[g], p0_mode_b_r[g]},
                           p0_latch_r[g], p0_boost_r[g]);
         assign d1 = drive(m1, p1_latch_r[g], p1_boost_r[g]);
         assign d2 = drive({p2_mode_a[g], port2_second_mode_r[g]},
                           p2_latch_r[g], p2_boost_r[g]);
         always @* begin
            p0_pull_down[g] = d0[2];
            p0_strong_up[g] = d0[1];
            p0_weak_up[g]   = d0[0];
            p1_pull_down[g] = d1[2];
            p1_strong_up[g] = d1[1];
            p1_weak_up[g]   = d1[0];
            // crystal pins: no drive, no input
            p2_pull_down[g] = d2[2] & ~xtal_pin;
            p2_strong_up[g] = d2[1] & ~xtal_pin;
            p2_weak_up[g]   = d2[0] & ~xtal_pin;
            p2_in_enable[g] = ~xtal_pin;
            // clock out overrides port 2 bit 0 drive when active and bit 0 is not a crystal pin
            if (g == 0 && clock_out_active && !xtal_pin) begin
               p2_pull_down[g] = ~clock_out_pin;
               p2_strong_up[g] = clock_out_pin;
               p2_weak_up[g]   = 1'b0;
            end
            p0_schmitt[g] = port2_aux_mode_r[`AUX_P0_SCHMITT];
            p2_schmitt[g] = port2_aux_mode_r[`AUX_P2_SCHMITT];
            if (g == 2 || g == 3) begin
               p1_schmitt[g] = 1'b1;
            end else if (g == 5) begin
               // pin 5 input exists only when reset pin is not external
               p1_schmitt[g] = internal_reset;
            end else begin
               p1_schmitt[g] = port2_aux_mode_r[`AUX_P1_SCHMITT];
            end
         end
      end
   endgenerate

   // -------------------------------------------------------------------
   // strong pull-up boost after latch rises (quasi mode)
   // -------------------------------------------------------------------
   // the boost needs a counter per pin; two clocks fit a 2-stage shift
   reg [7:0] p0_boost2_r;
   reg [7:0] p1_boost2_r;
   reg [7:0] p2_boost2_r;
   always @(posedge clk) begin
      if (sys_rst) begin
         p0_boost_r  <= 8'h00;
         p1_boost_r  <= 8'h00;
         p2_boost_r  <= 8'h00;
         p0_boost2_r <= 8'h00;
         p1_boost2_r <= 8'h00;
         p2_boost2_r <= 8'h00;
      end else begin
         // boost starts one cycle after the latch rises and lasts two clocks
         p0_boost_r  <= (p0_latch_r & ~p0_latch_d_r) | p0_boost2_r;
         p1_boost_r  <= (p1_latch_r & ~p1_latch_d_r) | p1_boost2_r;
         p2_boost_r  <= (p2_latch_r & ~p2_latch_d_r) | p2_boost2_r;
         p0_boost2_r <= p0_latch_r & ~p0_latch_d_r;
         p1_boost2_r <= p1_latch_r & ~p1_latch_d_r;
         p2_boost2_r <= p2_latch_r & ~p2_latch_d_r;
      end
   end

   // -------------------------------------------------------------------
   // pin synchronisers
   // -------------------------------------------------------------------
   // third stage lets a change count only once stages two and three agree
   always @(posedge clk) begin
      if (sys_rst) begin
         p0_s1_r   <= 8'hff;
         p0_s2_r   <= 8'hff;
         p0_s3_r   <= 8'hff;
         p0_sync_r <= 8'hff;
         {p1_s1_r, p1_s2_r, p1_s3_r, p1_sync_r} <= 32'h0;
         {p2_s1_r, p2_s2_r, p2_s3_r, p2_sync_r} <= 32'h0;
      end else begin
         p0_s1_r <= p0_in;
         p0_s2_r <= p0_s1_r;
         p0_s3_r <= p0_s2_r;
         p0_sync_r <= (p0_s2_r & p0_s3_r) | (p0_sync_r & (p0_s2_r ^ p0_s3_r));
         p1_s1_r <= p1_in;
         p1_s2_r <= p1_s1_r;
         p1_s3_r <= p1_s2_r;
         p1_sync_r <= (p1_s2_r & p1_s3_r) | (p1_sync_r & (p1_s2_r ^ p1_s3_r));
         p2_s1_r <= p2_in & p2_in_enable;
         p2_s2_r <= p2_s1_r;
         p2_s3_r <= p2_s2_r;
         p2_sync_r <= (p2_s2_r & p2_s3_r) | (p2_sync_r & (p2_s2_r ^ p2_s3_r));
      end
   end

   // -------------------------------------------------------------------
   // keypad flag, irq and wake
   // -------------------------------------------------------------------
   assign kp_hit = |(keypad_enable_mask_r & ~p0_sync_r);
   assign kp_flag_clr = reg_wr && (reg_addr == `ADDR_AUX_CONTROL) &&
                        !reg_wdata[`AUXC_KEYPAD_FLAG];
   assign keypad_irq = keypad_flag_r & keypad_irq_enable;
   // raw pins gated by mask: works with the clock stopped
   assign keypad_wake = keypad_irq_enable &
                        (keypad_flag_r | |(keypad_enable_mask_r & ~p0_in));

   // -------------------------------------------------------------------
   // register writes
   // -------------------------------------------------------------------
   always @(posedge clk) begin
      if (sys_rst) begin
         keypad_enable_mask_r <= `RST_ZERO;
         port2_aux_mode_r     <= `RST_ZERO;
         port2_second_mode_r  <= `RST_ZERO;
         p0_mode_a_r          <= `RST_ZERO;
         p0_mode_b_r          <= `RST_ZERO;
         p1_mode_a_r          <= `RST_ZERO;
         p1_mode_b_r          <= `RST_ZERO;
         p0_latch_r           <= rst_latch;
         p1_latch_r           <= rst_latch;
         p2_latch_r           <= rst_latch;
         keypad_flag_r        <= 1'b0;
      end else begin
         if (reg_wr) begin
            case (reg_addr)
               `ADDR_KEYPAD_MASK:    keypad_enable_mask_r <= reg_wdata;
               `ADDR_P2_AUX_MODE:    port2_aux_mode_r     <= reg_wdata;
               `ADDR_P2_SECOND_MODE: port2_second_mode_r  <= reg_wdata;
               `ADDR_P0_MODE_A:      p0_mode_a_r          <= reg_wdata;
               `ADDR_P0_MODE_B:      p0_mode_b_r          <= reg_wdata;
               `ADDR_P1_MODE_A:      p1_mode_a_r          <= reg_wdata;
               `ADDR_P1_MODE_B:      p1_mode_b_r          <= reg_wdata;
               `ADDR_PORT0_LATCH:    p0_latch_r           <= reg_wdata;
               `ADDR_PORT1_LATCH:    p1_latch_r           <= reg_wdata;
               `ADDR_PORT2_LATCH:    p2_latch_r           <= reg_wdata;
               default: ;
            endcase
         end
         // set wins over a software clear in the same cycle
         if (kp_hit) begin
            keypad_flag_r <= 1'b1;
         end else if (kp_flag_clr) begin
            keypad_flag_r <= 1'b0;
         end
      end
   end

   // previous latch values, for rising edge detect
   always @(posedge clk) begin
      if (sys_rst) begin
         p0_latch_d_r <= 8'hff;
         p1_latch_d_r <= 8'hff;
         p2_latch_d_r <= 8'hff;
      end else begin
         p0_latch_d_r <= p0_latch_r;
         p1_latch_d_r <= p1_latch_r;
         p2_latch_d_r <= p2_latch_r;
      end
   end

   // -------------------------------------------------------------------
   // timer toggles and clock out
   // -------------------------------------------------------------------
   // one flip per overflow gives half the overflow rate
   always @(posedge clk) begin
      if (sys_rst) begin
         timer0_toggle    <= 1'b0;
         timer1_toggle    <= 1'b0;
         clk_div_r        <= 3'h0;
         clock_out_pin    <= 1'b0;
         clock_out_active <= 1'b0;
      end else begin
         if (port2_aux_mode_r[`AUX_T0_TOGGLE_EN] && timer0_ovf) begin
            timer0_toggle <= ~timer0_toggle;
         end
         if (port2_aux_mode_r[`AUX_T1_TOGGLE_EN] && timer1_ovf) begin
            timer1_toggle <= ~timer1_toggle;
         end
         clock_out_active <= port2_aux_mode_r[`AUX_CLK_OUT_EN] &
                             rc_or_ext_clk;
         // three high, three low: one sixth of clk
         if (clk_div_r == `CLK_OUT_DIV - 3'h1) begin
            clk_div_r <= 3'h0;
         end else begin
            clk_div_r <= clk_div_r + 3'h1;
         end
         clock_out_pin <= (clk_div_r < 3'h3);
      end
   end

   // -------------------------------------------------------------------
   // register reads, one cycle latency
   // -------------------------------------------------------------------
   always @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `ADDR_KEYPAD_MASK:    reg_rdata <= keypad_enable_mask_r;
            `ADDR_P2_AUX_MODE:    reg_rdata <= port2_aux_mode_r;
            `ADDR_P2_SECOND_MODE: reg_rdata <= port2_second_mode_r;
            `ADDR_P0_MODE_A:      reg_rdata <= p0_mode_a_r;
            `ADDR_P0_MODE_B:      reg_rdata <= p0_mode_b_r;
            `ADDR_P1_MODE_A:      reg_rdata <= p1_mode_a_r;
            `ADDR_P1_MODE_B:      reg_rdata <= p1_mode_b_r;
            `ADDR_PORT0_LATCH:    reg_rdata <= p0_latch_r;
            `ADDR_PORT1_LATCH:    reg_rdata <= p1_latch_r;
            `ADDR_PORT2_LATCH:    reg_rdata <= p2_latch_r;
            `ADDR_AUX_CONTROL:    reg_rdata <= {6'h00, keypad_flag_r, 1'b0};
            `ADDR_P0_PINS:        reg_rdata <= p0_sync_r;
            `ADDR_P1_PINS:        reg_rdata <= p1_sync_r;
            `ADDR_P2_PINS:        reg_rdata <= p2_sync_r;
            default:              reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

endmodule

//--- tb/port_cfg_props.sv
// concurrent checks on the port block's pins and register writes
`timescale 1ns/10ps
`include "port_cfg_consts.vh"
module port_cfg_props #(
   parameter NPIN = 8
) (
   // clock, reset and register writes
   input wire            clk,
   input wire            sys_rst,
   input wire [7:0]      reg_addr,
   input wire [7:0]      reg_wdata,
   input wire            reg_wr,
   // configuration and timer inputs
   input wire            internal_reset,
   input wire            crystal_osc,
   input wire            rc_or_ext_clk,
   input wire            keypad_irq_enable,
   input wire            timer0_ovf,
   input wire            timer1_ovf,
   // pins and outputs watched
   input wire [NPIN-1:0] p0_in,
   input wire [NPIN-1:0] p1_weak_up,
   input wire [NPIN-1:0] p1_strong_up,
   input wire [NPIN-1:0] p0_schmitt,
   input wire [NPIN-1:0] p1_schmitt,
   input wire [NPIN-1:0] p2_in_enable,
   input wire            timer0_toggle,
   input wire            timer1_toggle,
   input wire            clock_out_active,
   input wire            keypad_irq,
   input wire            keypad_wake
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // --------
   // shadow copies of the two mapped registers
   // --------
   reg  [7:0] aux_r;
   reg  [7:0] mask_r;
   wire       t0_kick = timer0_ovf & aux_r[2];
   wire       t1_kick = timer1_ovf & aux_r[3];
   wire       pressed = keypad_irq_enable && |(mask_r & ~p0_in[7:0]);
   // follow software writes so the checks know which enables are set
   always @(posedge clk) begin
      if (sys_rst) begin
         aux_r  <= 8'h00;
         mask_r <= 8'h00;
      end else if (reg_wr && reg_addr == `ADDR_P2_AUX_MODE) begin
         aux_r  <= reg_wdata;
      end else if (reg_wr && reg_addr == `ADDR_KEYPAD_MASK) begin
         mask_r <= reg_wdata;
      end
   end
   // --------
   // properties
   // --------
   property p_od; p1_strong_up[3:2] == 2'h0 && p1_weak_up[3:2] == 2'h0;
   endproperty
   a_od: assert property (p_od) else $error("p1 bits 2,3 pulled up");
   property p_st; p1_schmitt[3:2] == 2'h3; endproperty
   a_st: assert property (p_st) else $error("p1 bits 2,3 not schmitt");
   property p_rs; p1_schmitt[5] == internal_reset; endproperty
   a_rs: assert property (p_rs) else $error("p1 bit 5 schmitt wrong");
   property p_xt; crystal_osc |-> p2_in_enable[1:0] == 2'h0; endproperty
   a_xt: assert property (p_xt) else $error("p2 bits 1:0 live");
   property p_sc;
      p0_schmitt == {NPIN{aux_r[5]}} && p1_schmitt[1:0] == {2{aux_r[6]}};
   endproperty
   a_sc: assert property (p_sc) else $error("port schmitt select");
   property p_t0;
      1 |=> timer0_toggle == ($past(timer0_toggle) ^ $past(t0_kick));
   endproperty
   a_t0: assert property (p_t0) else $error("timer0 toggle wrong");
   property p_t1;
      1 |=> timer1_toggle == ($past(timer1_toggle) ^ $past(t1_kick));
   endproperty
   a_t1: assert property (p_t1) else $error("timer1 toggle wrong");
   property p_ck; 1 |=> clock_out_active == $past(aux_r[4] & rc_or_ext_clk);
   endproperty
   a_ck: assert property (p_ck) else $error("clock out enable");
   property p_iq; keypad_irq |-> keypad_irq_enable; endproperty
   a_iq: assert property (p_iq) else $error("irq without enable");
   property p_hd; keypad_irq && !(reg_wr && reg_addr == `ADDR_AUX_CONTROL)
      |=> keypad_irq || !keypad_irq_enable; endproperty
   a_hd: assert property (p_hd) else $error("flag dropped by itself");
   property p_wk; pressed |-> keypad_wake; endproperty
   a_wk: assert property (p_wk) else $error("no wake on key");
   property p_ks; pressed [*8] |-> keypad_irq; endproperty
   a_ks: assert property (p_ks) else $error("flag not set on key");
endmodule

//--- tb/keypad_model.sv
// keypad switches and pull-up resistors hanging on one port's pins
`timescale 1ns/10ps
module keypad_model (
   // pulldown enables from the port
   input  wire [7:0] pull_down,
   // keys closed to ground, one per pin
   input  wire [7:0] key_down,
   // level seen at the pins
   output wire [7:0] pin
);
   // resistors hold open pins high; a closed key or the pulldown wins
   assign pin = ~(key_down | pull_down);
endmodule

//--- tb/port_config_and_keypad_wake_tb_top.sv
// bench for the port configuration and keypad wake block
`timescale 1ns/10ps
`include "port_cfg_consts.vh"
module port_config_and_keypad_wake_tb_top;
   // --------
   // bench signals
   // --------
   logic        clk, sys_rst, reg_wr, reg_rd, t0_ovf, t1_ovf;
   logic        rst_hi, int_rst, xtal, rc_clk, kb_en, rd_seen;
   logic        par0, par1;
   logic [7:0]  reg_addr, reg_wdata, p2_pins, keys0, keys1;
   logic [7:0]  exp_q[$];
   logic [31:0] rnd;
   wire  [7:0]  reg_rdata, p0_pins, p1_pins, p0_dn, p1_dn;
   wire  [7:0]  p0_up, p0_wk, p1_up, p2_dn, p2_up, p2_wk, p2_sch;
   wire         t0_tog, t1_tog, kb_irq, kb_wake, ck_out;
   integer      errors, check_count, cyc, i, cnt;
   port_config_and_keypad_wake dut (
      .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .reset_level_high(rst_hi),
      .internal_reset(int_rst), .crystal_osc(xtal),
      .rc_or_ext_clk(rc_clk), .keypad_irq_enable(kb_en),
      .timer0_ovf(t0_ovf), .timer1_ovf(t1_ovf), .p0_in(p0_pins),
      .p1_in(p1_pins), .p2_in(p2_pins), .p0_pull_down(p0_dn),
      .p1_pull_down(p1_dn), .p2_pull_down(p2_dn), .p0_strong_up(p0_up),
      .p1_strong_up(p1_up), .p2_strong_up(p2_up), .p0_weak_up(p0_wk),
      .p1_weak_up(), .p2_weak_up(p2_wk), .p0_schmitt(), .p1_schmitt(),
      .p2_schmitt(p2_sch), .p2_in_enable(), .timer0_toggle(t0_tog),
      .timer1_toggle(t1_tog), .clock_out_pin(ck_out), .clock_out_active(),
      .keypad_irq(kb_irq), .keypad_wake(kb_wake));
   keypad_model kp0 (.pull_down(p0_dn), .key_down(keys0), .pin(p0_pins));
   keypad_model kp1 (.pull_down(p1_dn), .key_down(keys1), .pin(p1_pins));
   // --------
   // helpers
   // --------
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task check(input logic [7:0] seen, input logic [7:0] exp);
      check_count = check_count + 1;
      if (seen !== exp) begin
         errors = errors + 1;
         $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task tick(input integer k);
      repeat (k) @(posedge clk);
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask
   // the expected byte is queued now and compared when the data stand
   task rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      exp_q.push_back(exp);
      @(posedge clk);
      reg_rd   <= 1'b0;
   endtask
   task results;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // read data stand only in the cycle after the strobe
   always @(posedge clk) begin
      if (rd_seen) check(reg_rdata, exp_q.pop_front());
      rd_seen <= reg_rd;
   end
   // a hang is cut short long after the sequence should have ended
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc > 5000) begin
         errors = errors + 1;
         results;
      end
   end
   // --------
   // main sequence
   // --------
   initial begin
      {sys_rst, rst_hi, int_rst, xtal, rc_clk, kb_en} = 6'h3b;
      {reg_wr, reg_rd, t0_ovf, t1_ovf, rd_seen} = 5'h00;
      {reg_addr, reg_wdata, keys0, keys1, p2_pins} = 40'h0;
      {errors, check_count, cyc} = 0;
      rnd = 32'hefef;
      // both reset levels, the second reset in mid-run
      for (i = 0; i < 2; i = i + 1) begin
         rst_hi  <= i[0];
         sys_rst <= 1'b1;
         tick(2);
         sys_rst <= 1'b0;
         @(negedge clk);
         check(p0_up, 8'h00);
         check(p0_dn, {8{~i[0]}});
         rd(`ADDR_PORT0_LATCH, {8{i[0]}});
         rd(`ADDR_KEYPAD_MASK, 8'h00);
         rd(`ADDR_P2_AUX_MODE, 8'h00);
         rd(8'h55, 8'h00);
      end
      // random timer overflows with both toggle outputs enabled
      wr(`ADDR_P2_AUX_MODE, 8'h0c);
      {par0, par1} = 2'h0;
      repeat (40) begin
         @(posedge clk);
         rnd = lfsr(rnd);
         {t1_ovf, t0_ovf} <= rnd[1:0];
         par0 = par0 ^ rnd[0];
         par1 = par1 ^ rnd[1];
      end
      @(posedge clk);
      {t1_ovf, t0_ovf} <= 2'h0;
      tick(1);
      @(negedge clk);
      check({6'h0, t1_tog, t0_tog}, {6'h0, par1, par0});
      // random register contents and static configuration
      repeat (4) begin
         @(posedge clk);
         rnd = lfsr(rnd);
         {int_rst, xtal, rc_clk, kb_en} <= rnd[19:16];
         p2_pins <= rnd[31:24];
         wr(`ADDR_KEYPAD_MASK, rnd[7:0]);
         wr(`ADDR_P2_AUX_MODE, rnd[15:8]);
         rd(`ADDR_KEYPAD_MASK, rnd[7:0]);
         rd(`ADDR_P2_AUX_MODE, rnd[15:8]);
      end
      {int_rst, xtal, rc_clk, kb_en} <= 4'h9;
      // every output mode with the latch low and high
      for (i = 0; i < 8; i = i + 1) begin
         wr(`ADDR_PORT0_LATCH, {8{i[2]}});
         wr(`ADDR_P0_MODE_A, {8{i[1]}});
         wr(`ADDR_P0_MODE_B, {8{i[0]}});
         tick(4);
         @(negedge clk);
         check(p0_up, (i == 5) ? 8'hff : 8'h00);
         check(p0_dn, (i[1:0] != 2'h2 && !i[2]) ? 8'hff : 8'h00);
         if (i[1]) check(p0_wk, 8'h00);
      end
      // quasi latch rising: strong pull-up for a fixed short burst
      wr(`ADDR_P0_MODE_A, 8'h00);
      wr(`ADDR_P0_MODE_B, 8'h00);
      wr(`ADDR_PORT0_LATCH, 8'h00);
      wr(`ADDR_PORT0_LATCH, 8'hff);
      cnt = 0;
      repeat (6) begin
         @(posedge clk);
         #1;
         if (p0_up === 8'hff) cnt = cnt + 1;
      end
      check(cnt[7:0], 8'h02);
      // fixed open-drain pins read back as inputs
      wr(`ADDR_P1_MODE_B, 8'hff);
      wr(`ADDR_PORT1_LATCH, 8'hff);
      keys1 <= 8'h04;
      tick(8);
      @(negedge clk);
      check(p1_up & 8'hdf, 8'hd3);
      rd(`ADDR_P1_PINS, 8'hfb);
      // port 2: pins 1,0 take bit_a from aux mode, then crystal, clock out
      wr(`ADDR_PORT2_LATCH, 8'hfc);
      wr(`ADDR_P2_SECOND_MODE, 8'h02);
      wr(`ADDR_P2_AUX_MODE, 8'h83);
      tick(4);
      @(negedge clk);
      check(p2_dn, 8'h02);
      check(p2_wk, 8'hfc);
      check(p2_sch, 8'hff);
      tick(1);
      xtal <= 1'b1;
      @(negedge clk);
      check(p2_dn, 8'h00);
      tick(1);
      {xtal, rc_clk} <= 2'h1;
      wr(`ADDR_P2_AUX_MODE, 8'h93);
      tick(1);
      cnt = 0;
      repeat (12) begin
         @(negedge clk);
         cnt = cnt + ck_out;
         check({7'h0, p2_up[0]}, {7'h0, ck_out});
      end
      check(cnt[7:0], 8'h06);
      // each keypad pin alone: set, hold, gate and clear
      for (i = 0; i < 8; i = i + 1) begin
         wr(`ADDR_KEYPAD_MASK, 8'h01 << i);
         keys0 <= ~(8'h01 << i);
         wr(`ADDR_AUX_CONTROL, 8'h00);
         tick(8);
         @(negedge clk);
         check({7'h0, kb_irq}, 8'h00);
         tick(1);
         keys0 <= 8'hff;
         tick(8);
         @(negedge clk);
         check({6'h0, kb_irq, kb_wake}, 8'h03);
         tick(1);
         keys0 <= 8'h00;
         tick(8);
         @(negedge clk);
         check({6'h0, kb_irq, kb_wake}, 8'h03);
         tick(1);
         kb_en <= 1'b0;
         @(negedge clk);
         check({6'h0, kb_irq, kb_wake}, 8'h00);
         tick(1);
         kb_en <= 1'b1;
      end
      tick(2);
      results;
   end
endmodule
bind port_config_and_keypad_wake port_cfg_props #(.NPIN(NPIN)) props (
   .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .internal_reset(internal_reset), .crystal_osc(crystal_osc),
   .rc_or_ext_clk(rc_or_ext_clk), .keypad_irq_enable(keypad_irq_enable),
   .timer0_ovf(timer0_ovf), .timer1_ovf(timer1_ovf), .p0_in(p0_in),
   .p1_weak_up(p1_weak_up), .p1_strong_up(p1_strong_up),
   .p0_schmitt(p0_schmitt), .p1_schmitt(p1_schmitt),
   .p2_in_enable(p2_in_enable), .timer0_toggle(timer0_toggle),
   .timer1_toggle(timer1_toggle), .clock_out_active(clock_out_active),
   .keypad_irq(keypad_irq), .keypad_wake(keypad_wake));
